// ===== hmw_defs.svh
// offsets, field positions, reset values and codes of the host memory window unit
`ifndef HMW_DEFS_SVH
`define HMW_DEFS_SVH
`define HMW_OFS_H2C_MBOX   3'h0
`define HMW_OFS_C2H_MBOX   3'h1
`define HMW_OFS_ADDR_LO    3'h2
`define HMW_OFS_ADDR_HI    3'h3
`define HMW_OFS_DATA0      3'h4
`define HMW_OFS_DATA1      3'h5
`define HMW_OFS_DATA2      3'h6
`define HMW_OFS_DATA3      3'h7
`define HMW_RST_BYTE       8'h00
`define HMW_REGION_BIT     7
`define HMW_ACC_AUTO32     2'h3
`define HMW_ACC_32         2'h2
`define HMW_ACC_16         2'h1
`define HMW_ACC_8          2'h0
`endif

// ===== hmw_pkg.sv
// types of the host memory window unit
package hmw_pkg;
  typedef enum logic [1:0] {
    HMW_IDLE,
    HMW_READ,
    HMW_WRITE
  } hmw_state_e;
  typedef struct packed {
    logic        region;
    logic [12:0] dword;
    logic [1:0]  access;
  } hmw_addr_s;
endpackage : hmw_pkg

// ===== hmw_host_memory_window_unit.sv
// both mailboxes, window address and the four data bytes of the host memory window unit
`timescale 1ns/1ps
`include "hmw_defs.svh"
module hmw_host_memory_window_unit (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        host_wr,
  input  wire logic        host_rd,
  input  wire logic [2:0]  host_addr,
  input  wire logic [7:0]  host_wdata,
  output logic      [7:0]  host_rdata,
  output logic             host_ack,
  input  wire logic        ctl_mbox_wr,
  input  wire logic [7:0]  ctl_mbox_wdata,
  output logic      [7:0]  host_to_controller_mailbox_byte,
  output logic             host_mbox_event,
  output logic             ctl_mbox_event,
  output logic             mem_req,
  output logic             mem_we,
  output logic             mem_region,
  output logic      [14:0] mem_addr,
  output logic      [3:0]  mem_be,
  output logic      [31:0] mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata
);
  // ==========================================================
  // registers
  logic [7:0]           controller_to_host_mailbox_byte_r;
  logic [7:0]           h2c_r;
  logic [5:0]           addr_lo_r;
  logic [1:0]           access_r;
  logic [6:0]           addr_hi_r;
  logic                 region_r;
  logic [31:0]          data_r;
  hmw_pkg::hmw_state_e  state_r;
  logic [1:0]           lane_r;
  logic [7:0]           rdata_r;
  logic                 ack_r;
  logic                 c2h_ev_r;
  logic                 h2c_ev_r;
  logic [12:0]          dword_nxt;
  logic                 data_acc;
  logic                 busy;
  logic                 host_take;
  hmw_pkg::hmw_addr_s   win;

  assign busy     = (state_r != hmw_pkg::HMW_IDLE);
  // a request still held in its acknowledge cycle is not taken a second time
  assign host_take = !busy && !ack_r;
  assign data_acc = host_addr[2];
  assign win.region = region_r;
  assign win.dword  = {addr_hi_r, addr_lo_r};
  assign win.access = access_r;
  assign dword_nxt  = win.dword + 13'h0001;

  // ==========================================================
  // mailboxes
  always_ff @(posedge clk) begin
    if (reset) begin
      controller_to_host_mailbox_byte_r <= `HMW_RST_BYTE;
      c2h_ev_r <= 1'b0;
    end else begin
      c2h_ev_r <= ctl_mbox_wr;
      if (ctl_mbox_wr) begin
        controller_to_host_mailbox_byte_r <= ctl_mbox_wdata;
      end else if (host_wr && host_take && host_addr == `HMW_OFS_C2H_MBOX) begin
        controller_to_host_mailbox_byte_r <= controller_to_host_mailbox_byte_r & ~host_wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      h2c_r    <= `HMW_RST_BYTE;
      h2c_ev_r <= 1'b0;
    end else begin
      h2c_ev_r <= host_wr && host_take && host_addr == `HMW_OFS_H2C_MBOX;
      if (host_wr && host_take && host_addr == `HMW_OFS_H2C_MBOX) begin
        h2c_r <= host_wdata;
      end
    end
  end

  // ==========================================================
  // window address
  always_ff @(posedge clk) begin
    if (reset) begin
      addr_lo_r <= 6'h00;
      access_r  <= `HMW_ACC_8;
      addr_hi_r <= 7'h00;
      region_r  <= 1'b0;
    end else if (host_wr && host_take && host_addr == `HMW_OFS_ADDR_LO) begin
      addr_lo_r <= host_wdata[7:2];
      access_r  <= host_wdata[1:0];
    end else if (host_wr && host_take && host_addr == `HMW_OFS_ADDR_HI) begin
      region_r  <= host_wdata[`HMW_REGION_BIT];
      addr_hi_r <= host_wdata[6:0];
    end else if (state_r != hmw_pkg::HMW_IDLE && mem_ack && access_r == `HMW_ACC_AUTO32
                 && lane_r == 2'h3) begin
      {addr_hi_r, addr_lo_r} <= dword_nxt;
    end
  end

  // ==========================================================
  // data window access sequencer
  // 32-bit modes write memory at byte 3, 16-bit at the odd byte, 8-bit every byte
  function automatic logic lane_hits(input logic [1:0] acc, input logic [1:0] lane);
    case (acc)
      `HMW_ACC_8:  lane_hits = 1'b1;
      `HMW_ACC_16: lane_hits = lane[0];
      default:     lane_hits = (lane == 2'h3);
    endcase
  endfunction : lane_hits

  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= hmw_pkg::HMW_IDLE;
      lane_r  <= 2'h0;
      data_r  <= 32'h0000_0000;
    end else begin
      case (state_r)
        hmw_pkg::HMW_IDLE: begin
          if (host_wr && data_acc && !ack_r) begin
            lane_r <= host_addr[1:0];
            data_r[{host_addr[1:0], 3'h0} +: 8] <= host_wdata;
            if (lane_hits(access_r, host_addr[1:0])) begin
              state_r <= hmw_pkg::HMW_WRITE;
            end
          end else if (host_rd && data_acc && !ack_r) begin
            lane_r <= host_addr[1:0];
            state_r <= hmw_pkg::HMW_READ;
          end
        end
        hmw_pkg::HMW_READ: begin
          if (mem_ack) begin
            state_r <= hmw_pkg::HMW_IDLE;
            if (access_r == `HMW_ACC_8) begin
              data_r[{lane_r, 3'h0} +: 8] <= mem_rdata[{lane_r, 3'h0} +: 8];
            end else begin
              data_r <= mem_rdata;
            end
          end
        end
        hmw_pkg::HMW_WRITE: begin
          if (mem_ack) begin
            state_r <= hmw_pkg::HMW_IDLE;
          end
        end
        default: state_r <= hmw_pkg::HMW_IDLE;
      endcase
    end
  end

  // ==========================================================
  // memory port
  always_comb begin
    mem_be = 4'hf;
    case (access_r)
      `HMW_ACC_8:  mem_be = 4'h1 << lane_r;
      `HMW_ACC_16: mem_be = lane_r[1] ? 4'hc : 4'h3;
      default:     mem_be = 4'hf;
    endcase
  end
  assign mem_req    = busy;
  assign mem_we     = (state_r == hmw_pkg::HMW_WRITE);
  assign mem_region = win.region;
  assign mem_addr   = {win.dword, 2'b00};
  assign mem_wdata  = data_r;

  // ==========================================================
  // host read data and acknowledge
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_r <= 8'h00;
      ack_r   <= 1'b0;
    end else begin
      ack_r <= 1'b0;
      if (busy && mem_ack) begin
        ack_r <= 1'b1;
        if (state_r == hmw_pkg::HMW_READ) begin
          rdata_r <= mem_rdata[{lane_r, 3'h0} +: 8];
        end
      end else if (host_take && (host_wr || host_rd) && !(data_acc && (host_rd || lane_hits(access_r, host_addr[1:0])))) begin
        ack_r <= 1'b1;
        case (host_addr)
          `HMW_OFS_H2C_MBOX: rdata_r <= h2c_r;
          `HMW_OFS_C2H_MBOX: rdata_r <= controller_to_host_mailbox_byte_r;
          `HMW_OFS_ADDR_LO:  rdata_r <= {addr_lo_r, access_r};
          `HMW_OFS_ADDR_HI:  rdata_r <= {region_r, addr_hi_r};
          default:           rdata_r <= data_r[{host_addr[1:0], 3'h0} +: 8];
        endcase
      end
    end
  end

  assign host_rdata = rdata_r;
  assign host_ack   = ack_r;
  assign host_to_controller_mailbox_byte = h2c_r;
  assign host_mbox_event = c2h_ev_r;
  assign ctl_mbox_event  = h2c_ev_r;

  // ==========================================================
  // assertions
  c2h_event_a: assert property (@(posedge clk) disable iff (reset)
    ctl_mbox_wr |=> host_mbox_event && controller_to_host_mailbox_byte_r == $past(ctl_mbox_wdata))
    else $error("mailbox event missing");
  c2h_clear_a: assert property (@(posedge clk) disable iff (reset)
    (host_wr && host_take && !ctl_mbox_wr && host_addr == `HMW_OFS_C2H_MBOX) |=>
    controller_to_host_mailbox_byte_r == ($past(controller_to_host_mailbox_byte_r) & ~$past(host_wdata)))
    else $error("mailbox clear wrong");
  addr_align_a: assert property (@(posedge clk) disable iff (reset) mem_addr[1:0] == 2'b00)
    else $error("window address not aligned");
  access_load_a: assert property (@(posedge clk) disable iff (reset)
    (host_wr && host_take && host_addr == `HMW_OFS_ADDR_LO) |=> access_r == $past(host_wdata[1:0]))
    else $error("access type not loaded");
  region_load_a: assert property (@(posedge clk) disable iff (reset)
    (host_wr && host_take && host_addr == `HMW_OFS_ADDR_HI) |=>
    mem_region == $past(host_wdata[7]) && mem_addr[14:8] == $past(host_wdata[6:0]))
    else $error("segment or high address wrong");
  byte_read_a: assert property (@(posedge clk) disable iff (reset)
    (state_r == hmw_pkg::HMW_READ && mem_ack) |=> host_ack && host_rdata == $past(mem_rdata[{lane_r, 3'h0} +: 8]))
    else $error("byte read wrong");
  h2c_event_a: assert property (@(posedge clk) disable iff (reset)
    (host_wr && host_take && host_addr == `HMW_OFS_H2C_MBOX) |=> ctl_mbox_event)
    else $error("controller event missing");
  auto_inc_a: assert property (@(posedge clk) disable iff (reset)
    (busy && mem_ack && access_r == `HMW_ACC_AUTO32 && lane_r == 2'h3) |=> win.dword == $past(dword_nxt))
    else $error("auto increment wrong");
  cov_read_c:  cover property (@(posedge clk) state_r == hmw_pkg::HMW_READ && mem_ack);
  cov_write_c: cover property (@(posedge clk) state_r == hmw_pkg::HMW_WRITE && mem_ack);
  cov_auto_c:  cover property (@(posedge clk) busy && mem_ack && access_r == `HMW_ACC_AUTO32);
endmodule : hmw_host_memory_window_unit

// ===== hmw_mem_model.sv
// memory model answering the window's memory port, promptly or slowly
`timescale 1ns/1ps
module hmw_mem_model (
  input  wire logic        clk,
  input  wire logic        slow,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic        mem_region,
  input  wire logic [14:0] mem_addr,
  input  wire logic [3:0]  mem_be,
  input  wire logic [31:0] mem_wdata,
  output logic             mem_ack,
  output logic      [31:0] mem_rdata
);
  logic [31:0] mem [logic [13:0]];
  logic [31:0] word;
  logic [14:0] last_addr;
  logic [3:0]  last_be;
  logic        last_region;
  logic [31:0] last_wdata;
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 32'h5555aaaa;
    forever begin
      @(posedge clk);
      if (mem_req === 1'b1 && mem_ack !== 1'b1) begin
        if (slow) repeat (3) @(posedge clk);
        word = mem.exists({mem_region, mem_addr[14:2]}) ? mem[{mem_region, mem_addr[14:2]}] : 32'h0;
        for (int b = 0; b < 4; b++)
          if (mem_we && mem_be[b]) word[8*b +: 8] = mem_wdata[8*b +: 8];
        if (mem_we) mem[{mem_region, mem_addr[14:2]}] = word;
        {last_addr, last_be, last_region, last_wdata} = {mem_addr, mem_be, mem_region, mem_wdata};
        mem_rdata <= word;
        mem_ack <= 1'b1;
      end else begin
        // data is not held once the answer is gone
        mem_rdata <= ~mem_rdata;
        mem_ack <= 1'b0;
      end
    end
  end
endmodule : hmw_mem_model

// ===== tb_top.sv
// self-checking testbench of the host memory window unit
`timescale 1ns/1ps
module tb_top;
  logic        clk = 1'b0, reset = 1'b1, host_wr = 1'b0, host_rd = 1'b0, ctl_mbox_wr = 1'b0, slow = 1'b0;
  logic [2:0]  host_addr = 3'h0;
  logic [7:0]  host_wdata = 8'h00, ctl_mbox_wdata = 8'h00, host_rdata, host_to_controller_mailbox_byte;
  logic        host_ack, host_mbox_event, ctl_mbox_event, mem_req, mem_we, mem_region, mem_ack;
  logic [14:0] mem_addr;
  logic [3:0]  mem_be;
  logic [31:0] mem_wdata, mem_rdata;
  int          num_errors = 0, compares = 0, n_host_ev = 0, n_ctl_ev = 0;
  hmw_host_memory_window_unit DUT (.clk, .reset, .host_wr, .host_rd, .host_addr, .host_wdata, .host_rdata,
    .host_ack, .ctl_mbox_wr, .ctl_mbox_wdata, .host_to_controller_mailbox_byte, .host_mbox_event,
    .ctl_mbox_event, .mem_req, .mem_we, .mem_region, .mem_addr, .mem_be, .mem_wdata, .mem_ack, .mem_rdata);
  hmw_mem_model mm (.clk, .slow, .mem_req, .mem_we, .mem_region, .mem_addr, .mem_be, .mem_wdata, .mem_ack,
    .mem_rdata);
  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    n_host_ev <= n_host_ev + int'(host_mbox_event === 1'b1);
    n_ctl_ev <= n_ctl_ev + int'(ctl_mbox_event === 1'b1);
  end
  task automatic conclude;
    $display("errors %0d, compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check
  task automatic acc(input logic wr, input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk);
    host_wr <= wr;
    host_rd <= !wr;
    host_addr <= a;
    host_wdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (host_ack !== 1'b1 && n < 50);
    if (host_ack !== 1'b1) check("host_ack", 32'h1, {31'h0, host_ack});
    q = host_rdata;
    host_wr <= 1'b0;
    host_rd <= 1'b0;
  endtask : acc
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input string what, input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] q;
    acc(1'b0, a, 8'h00, q);
    check(what, {24'h0, exp}, {24'h0, q});
  endtask : rd
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    $display("unexpected watchdog: expected run end, seen timeout");
    conclude();
  end
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 6; i++) rd("reset value", 3'(i), 8'h00);
    ctl_mbox_wdata <= 8'ha5;
    ctl_mbox_wr <= 1'b1;
    @(posedge clk);
    ctl_mbox_wr <= 1'b0;
    rd("c2h mailbox", 3'h1, 8'ha5);
    check("host events", 32'h1, n_host_ev);
    wr(3'h1, 8'h21);
    rd("c2h cleared", 3'h1, 8'h84);
    wr(3'h0, 8'h3c);
    repeat (2) @(posedge clk);
    check("h2c byte", 32'h3c, host_to_controller_mailbox_byte);
    check("ctl events", 32'h1, n_ctl_ev);
    wr(3'h2, 8'h10);
    wr(3'h3, 8'h85);
    rd("addr high", 3'h3, 8'h85);
    wr(3'h4, 8'h5a);
    check("byte addr", 32'h0510, mm.last_addr);
    check("region", 32'h1, mm.last_region);
    check("lane0", 32'h15a, {mm.last_be, mm.last_wdata[7:0]});
    wr(3'h5, 8'h6b);
    check("lane1", 32'h26b, {mm.last_be, mm.last_wdata[15:8]});
    mm.mem[14'h2144] = 32'h0000c3e7;
    rd("fetch byte0", 3'h4, 8'he7);
    rd("fetch byte1", 3'h5, 8'hc3);
    wr(3'h2, 8'h11);
    wr(3'h4, 8'h01);
    wr(3'h5, 8'h02);
    check("half", 32'h30201, {mm.last_be, mm.last_wdata[15:0]});
    slow <= 1'b1;
    for (int m = 2; m < 4; m++) begin
      wr(3'h2, {6'h3f, m[1:0]});
      for (int b = 0; b < 4; b++) wr(3'(4 + b), 8'(8'h11 * (b + 1)));
      check("word data", 32'h44332211, mm.last_wdata);
      check("word addr", 32'h85fc, {mm.last_region, mm.last_addr});
    end
    rd("auto low", 3'h2, 8'h03);
    rd("auto high", 3'h3, 8'h86);
    mm.mem[14'h2180] = 32'hd4c3b2a1;
    rd("word fetch byte0", 3'h4, 8'ha1);
    rd("word fetch byte3", 3'h7, 8'hd4);
    rd("auto read low", 3'h2, 8'h07);
    conclude();
  end
endmodule : tb_top
